// ==== adsq_regs.vh ====
// Function
// - Reference select from control bits six to four
// - Control bit seven enables bypass capacitor
// - Scan enabled channels into own results
// - Injection channel with own settings
// - Per channel single-ended or differential input
// - Per channel choice of four acquisition times
// - Twelve bit default, alternate eight/ten
// - One-shot or continuous; software and pin trigger sources
// - Twenty bit accumulator with sign extension
// - Averaging enable by register or pin
// - Sample count two to count plus one
// - Averaged channel takes N consecutive samples
// - Shift bit set gives true average
// - Shift bit clear shifts by count minus three, zero for count three or less
// - Threshold pair low and high halves
// - Condition code selects range flag test
// - Working results copied at scan end
// - Regular channels double buffered, injection not
// - Flags for scan, saturation, range, overflow, collision
// - Acquisition times four to 1023 clocks
// - Conversion takes fourteen clocks at twelve bits
`ifndef ADSQ_REGS_VH
`define ADSQ_REGS_VH
`define ADSQ_A_CTRL      8'h00
`define ADSQ_A_SAMPLE    8'h04
`define ADSQ_A_TIME01    8'h08
`define ADSQ_A_TIME23    8'h0c
`define ADSQ_A_THRES     8'h10
`define ADSQ_A_COND      8'h14
`define ADSQ_A_START     8'h18
`define ADSQ_A_STATUS    8'h1c
`define ADSQ_A_INJCFG    8'h20
`define ADSQ_A_INJRES    8'h24
`define ADSQ_A_CHCFG     8'h40
`define ADSQ_A_RESULT    8'h80
`define ADSQ_CTRL_REF    6:4
`define ADSQ_CTRL_BYP    7
`define ADSQ_CTRL_SUBRES 8
`define ADSQ_CTRL_PLMODE 9
`define ADSQ_S_CNT       6:4
`define ADSQ_S_SHIFT     7
`define ADSQ_S_CONT      16
`define ADSQ_S_TRIGEN    17
`define ADSQ_C_DIFF      0
`define ADSQ_C_ALTRES    1
`define ADSQ_C_AVG       2
`define ADSQ_C_TIME      5:4
`define ADSQ_C_EN        31
`define ADSQ_ACQ_MIN     10'h004
`define ADSQ_CONV12      5'h0e
`define ADSQ_CONV10      5'h0c
`define ADSQ_CONV8       5'h0a
`define ADSQ_RESP_OKAY   2'h0
`define ADSQ_RESP_SLVERR 2'h2
`endif

// ==== adsq_postproc.v ====
`timescale 1ns/10ps
`include "adsq_regs.vh"
module adsq_postproc #(
    parameter ACCW = 20
) (
    input  wire            clk,
    input  wire            rstN,
    input  wire            clear,
    input  wire            sampleValid,
    input  wire [11:0]     sample,
    input  wire [1:0]      resMode,
    input  wire            diffMode,
    input  wire            shiftBit,
    input  wire [2:0]      avgCnt,
    input  wire [15:0]     lowThr,
    input  wire [15:0]     highThr,
    input  wire [1:0]      cond,
    output wire [15:0]     avgOut,
    output wire            rangeHit,
    output wire            satHit
);
    reg  [ACCW-1:0] acc_reg;
    wire [ACCW-1:0] ext;
    wire [ACCW-1:0] sumNow;
    wire [3:0]      shAmt;
    wire [ACCW-1:0] shifted;
    wire [11:0]     maxVal;
    assign ext = diffMode ? {{(ACCW-12){sample[11]}}, sample} : {{(ACCW-12){1'b0}}, sample};
    assign sumNow = acc_reg + ext;
    assign shAmt = shiftBit ? ({1'b0, avgCnt} + 4'h1) :
                   ((avgCnt > 3'h3) ? ({1'b0, avgCnt} - 4'h3) : 4'h0);
    assign shifted = diffMode ? $unsigned($signed(sumNow) >>> shAmt) : (sumNow >> shAmt);
    assign avgOut = shifted[15:0];
    assign maxVal = (resMode == 2'h2) ? 12'h0ff : ((resMode == 2'h1) ? 12'h3ff : 12'hfff);
    assign satHit = (sample == maxVal) || (sample == 12'h000);
    assign rangeHit = (cond == 2'h0) ? (avgOut < lowThr) :
                      (cond == 2'h1) ? ((avgOut >= lowThr) && (avgOut < highThr)) :
                      (cond == 2'h2) ? (avgOut >= highThr) :
                      ((avgOut < lowThr) || (avgOut >= highThr));
    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
            acc_reg <= {ACCW{1'b0}};
        else if (clear)
            acc_reg <= {ACCW{1'b0}};
        else if (sampleValid)
            acc_reg <= sumNow;
    end
endmodule

// ==== adsq_top.v ====
`timescale 1ns/10ps
`include "adsq_regs.vh"
module adsq_top #(
    parameter NCH = 8
) (
    input  wire         clk,
    input  wire         arst_n,
    input  wire [7:0]   s_axi_awaddr,
    input  wire         s_axi_awvalid,
    output reg          s_axi_awready,
    input  wire [31:0]  s_axi_wdata,
    input  wire [3:0]   s_axi_wstrb,
    input  wire         s_axi_wvalid,
    output reg          s_axi_wready,
    output reg  [1:0]   s_axi_bresp,
    output reg          s_axi_bvalid,
    input  wire         s_axi_bready,
    input  wire [7:0]   s_axi_araddr,
    input  wire         s_axi_arvalid,
    output reg          s_axi_arready,
    output reg  [31:0]  s_axi_rdata,
    output reg  [1:0]   s_axi_rresp,
    output reg          s_axi_rvalid,
    input  wire         s_axi_rready,
    input  wire         trigIn,
    input  wire         plAvgEn,
    input  wire         convDone,
    input  wire [11:0]  convData,
    output reg  [2:0]   refSel,
    output reg          bypassEn,
    output reg          convStart,
    output reg  [3:0]   muxSel,
    output reg          muxDiff,
    output reg  [1:0]   convRes,
    output reg          eventFlag
);
    localparam S_IDLE = 3'h0;
    localparam S_ACQ  = 3'h1;
    localparam S_CONV = 3'h2;
    localparam S_NEXT = 3'h3;
    localparam S_DONE = 3'h4;
    localparam INJ    = 4'h8;
    reg  [1:0]  rstSync_reg;
    wire        rstN;
    reg  [31:0] ctrl_reg;
    reg  [31:0] sample_reg;
    reg  [31:0] time01_reg;
    reg  [31:0] time23_reg;
    reg  [31:0] thres_reg;
    reg  [1:0]  cond_reg;
    reg  [31:0] injCfg_reg;
    reg  [15:0] injRes_reg;
    reg  [31:0] chCfg_reg [0:NCH-1];
    reg  [15:0] work_reg [0:NCH-1];
    reg  [15:0] result_reg [0:NCH-1];
    reg  [NCH-1:0] rangeW_reg;
    reg  [NCH-1:0] rangeR_reg;
    reg  [5:0]  stat_reg;
    reg  [2:0]  state_reg;
    reg  [3:0]  ch_reg;
    reg  [9:0]  cnt_reg;
    reg  [8:0]  nLeft_reg;
    reg         scanReq_reg;
    reg         oneShot_reg;
    reg         trigPrev_reg;
    reg  [7:0]  wAddr_reg;
    reg         wHave_reg;
    reg  [31:0] wData_reg;
    reg         dHave_reg;
    wire [31:0] cfg;
    wire [1:0]  tSel;
    wire [9:0]  acqT;
    wire        avgOn;
    wire [8:0]  nSamp;
    wire [15:0] avgOut;
    wire        rangeHit;
    wire        satHit;
    wire        lastSample;
    wire        trigEdge;
    wire        swStart;
    wire        doWrite;
    wire [7:0]  wa;
    wire [7:0]  ra;
    reg  [3:0]  nextCh;
    reg  [31:0] rd;
    integer     k;
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rstSync_reg <= 2'h0;
        else
            rstSync_reg <= {rstSync_reg[0], 1'b1};
    end
    assign rstN = rstSync_reg[1];
    assign cfg = (ch_reg == INJ) ? injCfg_reg : chCfg_reg[ch_reg[2:0]];
    assign tSel = cfg[`ADSQ_C_TIME];
    assign acqT = (tSel == 2'h0) ? time01_reg[9:0] : (tSel == 2'h1) ? time01_reg[25:16] :
                  (tSel == 2'h2) ? time23_reg[9:0] : time23_reg[25:16];
    assign avgOn = ctrl_reg[`ADSQ_CTRL_PLMODE] ? plAvgEn : cfg[`ADSQ_C_AVG];
    assign nSamp = avgOn ? (9'h002 << sample_reg[`ADSQ_S_CNT]) : 9'h001;
    assign lastSample = (nLeft_reg == 9'h001);
    assign trigEdge = sample_reg[`ADSQ_S_TRIGEN] && trigIn && !trigPrev_reg;
    assign wa = wHave_reg ? wAddr_reg : s_axi_awaddr;
    assign doWrite = (wHave_reg || (s_axi_awvalid && s_axi_awready)) &&
                     (dHave_reg || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid;
    assign swStart = doWrite && (wa == `ADSQ_A_START);
    assign ra = s_axi_araddr;
    adsq_postproc #(
        .ACCW (20)
    ) u_pp (
        .clk         (clk),
        .rstN        (rstN),
        .clear       (state_reg == S_ACQ && cnt_reg == 10'h000 && nLeft_reg == 9'h000),
        .sampleValid (state_reg == S_CONV && convDone && !lastSample),
        .sample      (convData),
        .resMode     (convRes),
        .diffMode    (cfg[`ADSQ_C_DIFF]),
        .shiftBit    (avgOn && sample_reg[`ADSQ_S_SHIFT]),
        .avgCnt      (avgOn ? sample_reg[`ADSQ_S_CNT] : 3'h0),
        .lowThr      (thres_reg[15:0]),
        .highThr     (thres_reg[31:16]),
        .cond        (cond_reg),
        .avgOut      (avgOut),
        .rangeHit    (rangeHit),
        .satHit      (satHit)
    );
    always @*
    begin
        nextCh = INJ;
        for (k = NCH-1; k >= 0; k = k - 1)
            if (k > ch_reg && chCfg_reg[k][`ADSQ_C_EN] && ch_reg != INJ)
                nextCh = k[3:0];
        if (nextCh == INJ && !injCfg_reg[`ADSQ_C_EN])
            nextCh = 4'hf;
    end
    always @*
    begin
        rd = 32'h0000_0000;
        if (ra == `ADSQ_A_CTRL) rd = ctrl_reg;
        if (ra == `ADSQ_A_SAMPLE) rd = sample_reg;
        if (ra == `ADSQ_A_TIME01) rd = time01_reg;
        if (ra == `ADSQ_A_TIME23) rd = time23_reg;
        if (ra == `ADSQ_A_THRES) rd = thres_reg;
        if (ra == `ADSQ_A_COND) rd = {30'h0, cond_reg};
        if (ra == `ADSQ_A_STATUS) rd = {rangeR_reg, 16'h0, 2'h0, stat_reg};
        if (ra == `ADSQ_A_INJCFG) rd = injCfg_reg;
        if (ra == `ADSQ_A_INJRES) rd = {16'h0, injRes_reg};
        for (k = 0; k < NCH; k = k + 1)
        begin
            if (ra == `ADSQ_A_CHCFG + 4 * k) rd = chCfg_reg[k];
            if (ra == `ADSQ_A_RESULT + 4 * k) rd = {16'h0, result_reg[k]};
        end
    end
    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ADSQ_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ADSQ_RESP_OKAY;
            wHave_reg <= 1'b0;
            dHave_reg <= 1'b0;
            wAddr_reg <= 8'h00;
            wData_reg <= 32'h0000_0000;
            ctrl_reg <= 32'h0000_0040;
            sample_reg <= 32'h0000_0000;
            time01_reg <= {6'h0, `ADSQ_ACQ_MIN, 6'h0, `ADSQ_ACQ_MIN};
            time23_reg <= {6'h0, `ADSQ_ACQ_MIN, 6'h0, `ADSQ_ACQ_MIN};
            thres_reg <= 32'h0000_0000;
            cond_reg <= 2'h0;
            injCfg_reg <= 32'h0000_0000;
            for (k = 0; k < NCH; k = k + 1)
                chCfg_reg[k] <= 32'h0000_0000;
        end
        else
        begin
            s_axi_awready <= !wHave_reg && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !dHave_reg && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                wHave_reg <= 1'b1;
                wAddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                dHave_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
            end
            if (doWrite)
            begin
                wHave_reg <= 1'b0;
                dHave_reg <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `ADSQ_RESP_OKAY;
                case (wa)
                    `ADSQ_A_CTRL: ctrl_reg <= dHave_reg ? wData_reg : s_axi_wdata;
                    `ADSQ_A_SAMPLE: sample_reg <= dHave_reg ? wData_reg : s_axi_wdata;
                    `ADSQ_A_TIME01: time01_reg <= dHave_reg ? wData_reg : s_axi_wdata;
                    `ADSQ_A_TIME23: time23_reg <= dHave_reg ? wData_reg : s_axi_wdata;
                    `ADSQ_A_THRES: thres_reg <= dHave_reg ? wData_reg : s_axi_wdata;
                    `ADSQ_A_COND: cond_reg <= dHave_reg ? wData_reg[1:0] : s_axi_wdata[1:0];
                    `ADSQ_A_INJCFG: injCfg_reg <= dHave_reg ? wData_reg : s_axi_wdata;
                    `ADSQ_A_START, `ADSQ_A_STATUS: ;
                    default:
                    begin
                        s_axi_bresp <= `ADSQ_RESP_SLVERR;
                        for (k = 0; k < NCH; k = k + 1)
                            if (wa == `ADSQ_A_CHCFG + 4 * k)
                            begin
                                chCfg_reg[k] <= dHave_reg ? wData_reg : s_axi_wdata;
                                s_axi_bresp <= `ADSQ_RESP_OKAY;
                            end
                    end
                endcase
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd;
                s_axi_rresp <= (ra[1:0] != 2'h0 || ra > `ADSQ_A_RESULT + 8'h1c) ?
                               `ADSQ_RESP_SLVERR : `ADSQ_RESP_OKAY;
            end
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
    always @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            state_reg <= S_IDLE;
            ch_reg <= 4'h0;
            cnt_reg <= 10'h000;
            nLeft_reg <= 9'h000;
            scanReq_reg <= 1'b0;
            oneShot_reg <= 1'b0;
            trigPrev_reg <= 1'b0;
            stat_reg <= 6'h00;
            rangeW_reg <= {NCH{1'b0}};
            rangeR_reg <= {NCH{1'b0}};
            injRes_reg <= 16'h0000;
            convStart <= 1'b0;
            muxSel <= 4'h0;
            muxDiff <= 1'b0;
            convRes <= 2'h0;
            refSel <= 3'h4;
            bypassEn <= 1'b0;
            eventFlag <= 1'b0;
            for (k = 0; k < NCH; k = k + 1)
            begin
                work_reg[k] <= 16'h0000;
                result_reg[k] <= 16'h0000;
            end
        end
        else
        begin
            refSel <= ctrl_reg[`ADSQ_CTRL_REF];
            bypassEn <= ctrl_reg[`ADSQ_CTRL_BYP];
            trigPrev_reg <= trigIn;
            convStart <= 1'b0;
            eventFlag <= |stat_reg;
            if (doWrite && wa == `ADSQ_A_STATUS)
                stat_reg <= stat_reg & ~(dHave_reg ? wData_reg[5:0] : s_axi_wdata[5:0]);
            if (swStart || trigEdge)
            begin
                if (state_reg != S_IDLE)
                    stat_reg[4] <= 1'b1;
                scanReq_reg <= 1'b1;
            end
            case (state_reg)
                S_IDLE:
                    if (scanReq_reg || sample_reg[`ADSQ_S_CONT])
                    begin
                        scanReq_reg <= 1'b0;
                        ch_reg <= 4'h0;
                        state_reg <= S_NEXT;
                        oneShot_reg <= 1'b1;
                    end
                S_NEXT:
                begin
                    if (oneShot_reg && chCfg_reg[0][`ADSQ_C_EN])
                        ch_reg <= 4'h0;
                    else
                        ch_reg <= nextCh;
                    oneShot_reg <= 1'b0;
                    state_reg <= ((oneShot_reg && chCfg_reg[0][`ADSQ_C_EN]) || nextCh != 4'hf) ? S_ACQ : S_DONE;
                    cnt_reg <= 10'h000;
                    nLeft_reg <= 9'h000;
                end
                S_ACQ:
                begin
                    if (nLeft_reg == 9'h000)
                        nLeft_reg <= nSamp + 9'h001;
                    muxSel <= ch_reg;
                    muxDiff <= cfg[`ADSQ_C_DIFF];
                    convRes <= cfg[`ADSQ_C_ALTRES] ? (ctrl_reg[`ADSQ_CTRL_SUBRES] ? 2'h2 : 2'h1) : 2'h0;
                    cnt_reg <= cnt_reg + 10'h001;
                    if (cnt_reg + 10'h001 >= ((acqT < `ADSQ_ACQ_MIN) ? `ADSQ_ACQ_MIN : acqT))
                    begin
                        convStart <= 1'b1;
                        state_reg <= S_CONV;
                    end
                end
                S_CONV:
                    if (convDone)
                    begin
                        if (satHit)
                            stat_reg[1] <= 1'b1;
                        if (nLeft_reg > 9'h002)
                        begin
                            nLeft_reg <= nLeft_reg - 9'h001;
                            cnt_reg <= 10'h000;
                            state_reg <= S_ACQ;
                        end
                        else
                        begin
                            if (ch_reg == INJ)
                            begin
                                injRes_reg <= avgOut;
                                stat_reg[5] <= 1'b1;
                            end
                            else
                            begin
                                work_reg[ch_reg[2:0]] <= avgOut;
                                rangeW_reg[ch_reg[2:0]] <= rangeHit;
                            end
                            if (rangeHit)
                                stat_reg[2] <= 1'b1;
                            state_reg <= (ch_reg == INJ) ? S_IDLE : S_NEXT;
                            if (ch_reg != INJ && nextCh == INJ)
                                state_reg <= S_DONE;
                        end
                    end
                S_DONE:
                begin
                    for (k = 0; k < NCH; k = k + 1)
                        result_reg[k] <= work_reg[k];
                    rangeR_reg <= rangeW_reg;
                    stat_reg[0] <= 1'b1;
                    if (stat_reg[0])
                        stat_reg[3] <= 1'b1;
                    if (injCfg_reg[`ADSQ_C_EN] && ch_reg != INJ)
                    begin
                        ch_reg <= INJ;
                        cnt_reg <= 10'h000;
                        nLeft_reg <= 9'h000;
                        state_reg <= S_ACQ;
                    end
                    else
                        state_reg <= S_IDLE;
                end
                default:
                    state_reg <= S_IDLE;
            endcase
        end
    end
endmodule

// ==== adsq_assertions.sv ====
`timescale 1ns/10ps
`include "adsq_regs.vh"
module adsq_checker (
    input wire        clk,
    input wire        arst_n,
    input wire [7:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [2:0]  refSel,
    input wire        bypassEn,
    input wire        convStart,
    input wire [3:0]  muxSel,
    input wire [1:0]  convRes
);
    reg [3:0] refWr_reg;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    always @(posedge clk)
    begin
        if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == `ADSQ_A_CTRL)
            refWr_reg <= s_axi_wdata[7:4];
    end
    sequence wrTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence ctrlWr;
        wrTaken ##0 s_axi_awaddr == `ADSQ_A_CTRL;
    endsequence
    ref_follow_a: assert property (ctrlWr |-> ##[1:3] {bypassEn, refSel} == refWr_reg)
        else $error("Reference outputs miss control write");
    ref_code_a: assert property (refSel[2])
        else $error("Reference code outside four to seven");
    res_code_a: assert property (convRes != 2'h3)
        else $error("Unknown resolution code");
    mux_range_a: assert property (convStart |-> muxSel <= 4'h8)
        else $error("Conversion on unknown channel");
    mux_hold_a: assert property (convStart |-> $past(muxSel, 3) == muxSel)
        else $error("Channel changed inside acquisition");
    conv_gap_a: assert property (convStart |=> !convStart [*3])
        else $error("Conversions closer than acquisition");
    wr_answer_a: assert property (wrTaken |=> s_axi_bvalid)
        else $error("Write response late");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read response late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("Write response dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data dropped");
endmodule

// ==== adsq_conv_model.sv ====
`timescale 1ns/10ps
module adsq_conv_model (
    input  wire        clk,
    input  wire        convStart,
    input  wire [3:0]  muxSel,
    input  wire        muxDiff,
    input  wire [1:0]  convRes,
    input  wire [11:0] base,
    output reg         convDone,
    output reg  [11:0] convData
);
    integer   hits [0:8];
    reg       diffSeen [0:8];
    reg [1:0] resSeen [0:8];
    integer   left = 0;
    reg [3:0] ch;
    always @(posedge clk)
    begin
        convDone <= 1'b0;
        convData <= ~convData;
        if (convStart && muxSel < 4'h9)
        begin
            ch = muxSel;
            hits[ch] = hits[ch] + 1;
            diffSeen[ch] = muxDiff;
            resSeen[ch] = convRes;
            left = 14 - 2 * convRes;
        end
        else if (left == 1)
        begin
            convDone <= 1'b1;
            convData <= base + {ch, 4'h0};
            left = 0;
        end
        else if (left > 1)
            left = left - 1;
    end
endmodule

// ==== test_adc_scan_sequencer_postproc.sv ====
`timescale 1ns/10ps
`include "adsq_regs.vh"
module test_adc_scan_sequencer_postproc;
    localparam OK  = `ADSQ_RESP_OKAY;
    localparam ERR = `ADSQ_RESP_SLVERR;
    reg         clk, arst_n, awValid, wValid, bReady, arValid, rReady, trigIn;
    reg  [7:0]  awAddr, arAddr;
    reg  [31:0] wData, rd;
    reg  [11:0] base;
    wire        awReady, wReady, bValid, arReady, rValid, convDone, convStart, bypassEn, muxDiff, eventFlag;
    wire [1:0]  bResp, rResp, convRes;
    wire [31:0] rData;
    wire [11:0] convData;
    wire [2:0]  refSel;
    wire [3:0]  muxSel;
    integer     fails, checks_done, k;
    adsq_top DUT (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .trigIn(trigIn), .plAvgEn(1'b0),
        .convDone(convDone), .convData(convData), .refSel(refSel), .bypassEn(bypassEn), .convStart(convStart),
        .muxSel(muxSel), .muxDiff(muxDiff), .convRes(convRes), .eventFlag(eventFlag));
    adsq_conv_model PM (.clk(clk), .convStart(convStart), .muxSel(muxSel), .muxDiff(muxDiff),
        .convRes(convRes), .base(base), .convDone(convDone), .convData(convData));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task check(input [34:0] got, input [34:0] exp);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        integer n;
        reg     got;
    begin
        @(posedge clk);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        got = 0;
        for (n = 0; n < 100 && !got; n = n + 1)
        begin
            @(posedge clk);
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
            if (bValid) got = 1;
        end
        bReady <= 1'b0;
        check({got, bResp}, {1'b1, er});
    end
    endtask
    task rdc(input [7:0] a, input [31:0] msk, input [31:0] exp, input [1:0] er);
        integer n;
        reg     got;
    begin
        @(posedge clk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        got = 0;
        for (n = 0; n < 100 && !got; n = n + 1)
        begin
            @(posedge clk);
            if (arReady) arValid <= 1'b0;
            if (rValid) got = 1;
        end
        rReady <= 1'b0;
        rd = rData;
        check({~got, rResp, rData & msk}, {1'b0, er, exp});
    end
    endtask
    task waitBit(input integer b);
        integer n;
    begin
        rd = 0;
        for (n = 0; n < 3000 && !rd[b]; n = n + 1)
            rdc(`ADSQ_A_STATUS, 0, 0, OK);
        check(rd[b], 1);
    end
    endtask
    task scan(input [11:0] b, input clr);
        integer j;
    begin
        if (clr) wr(`ADSQ_A_STATUS, ~32'h0, OK);
        base <= b;
        @(negedge clk);
        for (j = 0; j < 9; j = j + 1)
            PM.hits[j] = 0;
        wr(`ADSQ_A_START, 32'h1, OK);
    end
    endtask
    function [31:0] cfg(input integer i);
        cfg = (i == 0) ? 32'h8000_0000 : (i == 1) ? 32'h8000_0004 : (i == 2) ? 32'h8000_0001 :
              (i == 5) ? 32'h8000_0032 : 32'h0;
    endfunction
    task tally_and_finish;
    begin
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    initial
    begin
        #2000000;
        fails = fails + 1;
        tally_and_finish;
    end
    initial
    begin
        fails = 0;
        checks_done = 0;
        arst_n = 1'b0;
        {awValid, wValid, bReady, arValid, rReady, trigIn} = 6'h0;
        {awAddr, arAddr, wData, base} = 60'h0;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check({refSel, bypassEn, eventFlag}, 5'h10);
        for (k = 4; k < 8; k = k + 1)
        begin
            wr(`ADSQ_A_CTRL, k * 16 + k % 2 * 128, OK);
            rdc(`ADSQ_A_CTRL, 32'hf0, k * 16 + k % 2 * 128, OK);
            check({bypassEn, refSel}, k + k % 2 * 8);
        end
        wr(`ADSQ_A_CTRL, 32'hc0, OK);
        repeat (8000) @(posedge clk);
        wr(`ADSQ_A_THRES, 32'h0120_0110, OK);
        rdc(`ADSQ_A_THRES, ~32'h0, 32'h0120_0110, OK);
        wr(8'hfc, 32'h1, ERR);
        rdc(8'hfc, ~32'h0, 32'h0, ERR);
        $display("Done: registers");
        wr(`ADSQ_A_TIME01, 32'h0004_0004, OK);
        wr(`ADSQ_A_TIME23, 32'h0004_0004, OK);
        for (k = 0; k < 8; k = k + 1)
            wr(`ADSQ_A_CHCFG + 4 * k, cfg(k), OK);
        wr(`ADSQ_A_SAMPLE, 32'h90, OK);
        scan(12'h100, 1);
        waitBit(0);
        for (k = 0; k < 9; k = k + 1)
            check(PM.hits[k], (k == 1) ? 4 : (cfg(k) != 0));
        check({PM.diffSeen[2], PM.diffSeen[0], PM.resSeen[5], PM.resSeen[0]}, 6'h24);
        for (k = 0; k < 3; k = k + 1)
            rdc(`ADSQ_A_RESULT + 4 * k, 32'hffff, 32'h100 + 16 * k, OK);
        $display("Done: scan");
        for (k = 0; k < 3; k = k + 1)
        begin
            wr(`ADSQ_A_SAMPLE, (k == 0) ? 32'h10 : (k == 1) ? 32'h40 : 32'hf0, OK);
            scan(12'h020, 1);
            waitBit(0);
            check(PM.hits[1], (k == 0) ? 4 : (k == 1) ? 32 : 256);
            rdc(`ADSQ_A_RESULT + 4, 32'hffff, (k == 0) ? 32'hc0 : (k == 1) ? 32'h300 : 32'h30, OK);
        end
        $display("Done: averaging");
        wr(`ADSQ_A_SAMPLE, 32'h90, OK);
        for (k = 0; k < 4; k = k + 1)
        begin
            wr(`ADSQ_A_COND, k, OK);
            scan(12'h100, 1);
            waitBit(0);
            rdc(`ADSQ_A_STATUS, 32'h0700_0000, {5'h0, (k == 3) ? 3'h5 : 3'h1 << k, 24'h0}, OK);
        end
        $display("Done: range");
        wr(`ADSQ_A_INJCFG, 32'h8000_0000, OK);
        scan(12'h300, 1);
        rdc(`ADSQ_A_RESULT, 32'hffff, 32'h100, OK);
        waitBit(0);
        waitBit(5);
        rdc(`ADSQ_A_INJRES, 32'hffff, 32'h380, OK);
        rdc(`ADSQ_A_RESULT, 32'hffff, 32'h300, OK);
        check(eventFlag, 1);
        scan(12'h300, 0);
        waitBit(3);
        rdc(`ADSQ_A_STATUS, 32'h29, 32'h29, OK);
        $display("Done: buffering");
        wr(`ADSQ_A_SAMPLE, 32'h0002_0090, OK);
        wr(`ADSQ_A_STATUS, ~32'h0, OK);
        trigIn <= 1'b1;
        waitBit(0);
        trigIn <= 1'b0;
        $display("Done: trigger");
        tally_and_finish;
    end
endmodule
bind adsq_top adsq_checker CHK (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .refSel(refSel),
    .bypassEn(bypassEn), .convStart(convStart), .muxSel(muxSel), .convRes(convRes));
